// ==== shared/swl_pkg.sv ====
// swl_pkg: register map, field positions, reset values and timing for the
// system wakeup / low-voltage / pending-summary control block.
// assumes a 32-bit apb slave with byte addresses, one aligned word per register.
package swl_pkg;

	// ****************************************************
	// register offsets (byte addresses)
	// ****************************************************
	localparam logic [7:0] SWL_OFF_WAKE = 8'h00; // periodic_wakeup_ctrl
	localparam logic [7:0] SWL_OFF_PWR = 8'h04; // power_monitor_ctrl
	localparam logic [7:0] SWL_OFF_PEND = 8'h08; // irq_pending_summary

	// ****************************************************
	// field positions
	// ****************************************************
	localparam int SWL_WK_FLAG = 7;
	localparam int SWL_WK_ACK = 6;
	localparam int SWL_WK_CLKS = 5;
	localparam int SWL_WK_IE = 4;
	localparam int SWL_PW_FLAG = 7;
	localparam int SWL_PW_ACK = 6;
	localparam int SWL_PW_IE = 5;
	localparam int SWL_PW_RE = 4;
	localparam int SWL_PW_SE = 3;
	localparam int SWL_PW_DE = 2;
	localparam int SWL_PW_BUF = 0;
	localparam int SWL_PD_KEY = 4;
	localparam int SWL_PD_CMP = 3;
	localparam int SWL_PD_TMR = 2;
	localparam int SWL_PD_WAKE = 1;
	localparam int SWL_PD_LV = 0;

	// ****************************************************
	// reset values
	// ****************************************************
	localparam logic [7:0] SWL_RST_WAKE = 8'h00;
	localparam logic [7:0] SWL_RST_PWR = 8'h00;

	// ****************************************************
	// timing
	// ****************************************************
	localparam int SWL_CLK_MHZ = 100;
	localparam int SWL_FAST_DIV = 32; // 32 khz divided down to 1 khz
	localparam int SWL_TICK_MS = 1; // wakeup tick period in ms
	localparam int SWL_TICK_CYC = SWL_TICK_MS * 1000 * SWL_CLK_MHZ;
	localparam logic [10:0] SWL_PER_8 = 11'h008;

endpackage : swl_pkg

// ==== verilog/swl_ctrl.sv ====
// swl_ctrl: periodic wakeup timer, low-voltage control/status and a
// read-only pending-interrupt summary, behind an apb slave.
// assumes clock pins from oscillators and the analog detector are asynchronous.
// Function
// - wakeup irq enable gates wakeup requests
// - period select 000 turns timer off
// - periods 8..1024 ticks of 1 ms
// - slow oscillator off only in stop: select 000, clksel 1
// - lowvolt flag sets only while detect enabled
// - lowvolt acknowledge write 1 clears, reads 0
// - lowvolt irq enable requests irq on flag
// - write-once reset enable forces device reset
// - stop enable keeps detection during stop
// - write-once detect enable qualifies lowvolt bits
// - write-once bits take first write only
// - reference buffer enable drives buffer output
// - summary bit 4: keypad flag and enable
// - summary bit 3: comparator flag and enable
// - summary bit 2: timer overflow flag, enable
// - summary bit 1: wakeup flag and enable
// - summary bit 0: lowvolt flag, ie, de
// - wakeup flag set on timer timeout
// - wakeup acknowledge write 1 clears, reads 0
// - clock select: 1 khz or 32 khz/32
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module swl_ctrl #(
	parameter int TICK_CYC = swl_pkg::SWL_TICK_CYC
) (
	// clock, enable and reset
	input wire logic sys_clk,
	input wire logic clk_en,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// asynchronous sources
	input wire logic slow_osc_clk,
	input wire logic fast_osc_clk,
	input wire logic lowvolt_detect,
	// peripheral flags and enables (same clock)
	input wire logic keypad_flag,
	input wire logic keypad_irq_enable,
	input wire logic comparator_flag,
	input wire logic comparator_irq_enable,
	input wire logic timer_overflow_flag,
	input wire logic timer_overflow_irq_enable,
	// system status
	input wire logic stop_mode,
	// outputs
	output logic periodic_wakeup_irq,
	output logic lowvolt_irq,
	output logic lowvolt_reset_req,
	output logic slow_osc_enable,
	output logic lowvolt_detector_on,
	output logic reference_buffer_enable
);
	import swl_pkg::*;

	// ****************************************************
	// helpers
	// ****************************************************

	// period in ticks for each select code
	function automatic logic [10:0] period_ticks(input logic [2:0] sel);
		logic [10:0] p;
		p = 11'h000;
		case (sel)
			3'h1: p = SWL_PER_8;
			3'h0: p = 11'h000;
			default: p = 11'(11'h008 << sel);
		endcase
		return p;
	endfunction : period_ticks

	// three-stage synchroniser with agreement of stages two and three
	function automatic logic sync_next(input logic [2:0] s, input logic held);
		return (s[1] == s[2]) ? s[2] : held;
	endfunction : sync_next

	// ****************************************************
	// input synchronisers
	// ****************************************************
	logic [2:0] slow_sync_reg, fast_sync_reg, lv_sync_reg;
	logic slow_lvl_reg, slow_lvl_next, fast_lvl_reg, fast_lvl_next;
	logic lv_lvl_reg, lv_lvl_next;

	// agreed levels of the asynchronous inputs
	always_comb begin
		slow_lvl_next = sync_next(slow_sync_reg, slow_lvl_reg);
		fast_lvl_next = sync_next(fast_sync_reg, fast_lvl_reg);
		lv_lvl_next = sync_next(lv_sync_reg, lv_lvl_reg);
	end

	// shift chains; first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			slow_sync_reg <= 3'h0;
			fast_sync_reg <= 3'h0;
			lv_sync_reg <= 3'h0;
			slow_lvl_reg <= 1'b0;
			fast_lvl_reg <= 1'b0;
			lv_lvl_reg <= 1'b0;
		end else if (clk_en) begin
			slow_sync_reg <= {slow_sync_reg[1:0], slow_osc_clk};
			fast_sync_reg <= {fast_sync_reg[1:0], fast_osc_clk};
			lv_sync_reg <= {lv_sync_reg[1:0], lowvolt_detect};
			slow_lvl_reg <= slow_lvl_next;
			fast_lvl_reg <= fast_lvl_next;
			lv_lvl_reg <= lv_lvl_next;
		end
	end

	// ****************************************************
	// registers
	// ****************************************************
	logic wk_flag_reg, wk_flag_next, wk_clks_reg, wk_clks_next, wk_ie_reg, wk_ie_next;
	logic [2:0] wk_sel_reg, wk_sel_next;
	logic lv_flag_reg, lv_flag_next, lv_ie_reg, lv_ie_next, lv_re_reg, lv_re_next;
	logic lv_se_reg, lv_se_next, lv_de_reg, lv_de_next, buf_reg, buf_next;
	logic re_done_reg, re_done_next, de_done_reg, de_done_next;
	logic [4:0] fdiv_reg, fdiv_next;
	logic [10:0] cnt_reg, cnt_next;
	logic slow_prev_reg, fast_prev_reg, tick_reg, tick_next;
	logic [31:0] prdata_reg, prdata_next;
	logic wr_wake, wr_pwr, acc, timeout, lv_event, lv_active;
	logic [7:0] pend;

	assign acc = psel && penable;
	assign wr_wake = acc && pwrite && (paddr == SWL_OFF_WAKE);
	assign wr_pwr = acc && pwrite && (paddr == SWL_OFF_PWR);

	// detection runs while enabled, and in stop only with stop enable
	assign lv_active = lv_de_reg && (!stop_mode || lv_se_reg);
	assign lv_event = lv_active && lv_lvl_reg;

	// wakeup timeout on a tick that arrives with the count at the selected period minus one
	assign timeout = (wk_sel_reg != 3'h0) && tick_reg
		&& (cnt_reg == 11'(period_ticks(wk_sel_reg) - 11'h001));

	// pending summary, one flag/enable pair per source, lowvolt also gated by detect enable
	always_comb begin
		pend = 8'h00;
		pend[SWL_PD_KEY] = keypad_flag && keypad_irq_enable;
		pend[SWL_PD_CMP] = comparator_flag && comparator_irq_enable;
		pend[SWL_PD_TMR] = timer_overflow_flag && timer_overflow_irq_enable;
		pend[SWL_PD_WAKE] = wk_flag_reg && wk_ie_reg;
		pend[SWL_PD_LV] = lv_flag_reg && lv_ie_reg && lv_de_reg;
	end

	// next state of tick source, counter and control bits
	always_comb begin
		fdiv_next = fdiv_reg;
		tick_next = 1'b0;
		cnt_next = cnt_reg;
		// divide the fast clock by 32 or use slow rising edges
		if (fast_lvl_reg && !fast_prev_reg) begin
			fdiv_next = 5'(fdiv_reg + 5'h01);
		end
		if (wk_clks_reg) begin
			tick_next = fast_lvl_reg && !fast_prev_reg
				&& (fdiv_reg == 5'(SWL_FAST_DIV - 1));
		end else begin
			tick_next = slow_lvl_reg && !slow_prev_reg;
		end
		if (wk_sel_reg == 3'h0) begin
			cnt_next = 11'h000;
		end else if (timeout) begin
			cnt_next = 11'h000;
		end else if (tick_reg) begin
			cnt_next = 11'(cnt_reg + 11'h001);
		end
		wk_flag_next = wk_flag_reg;
		wk_clks_next = wk_clks_reg;
		wk_ie_next = wk_ie_reg;
		wk_sel_next = wk_sel_reg;
		lv_flag_next = lv_flag_reg;
		lv_ie_next = lv_ie_reg;
		lv_re_next = lv_re_reg;
		lv_se_next = lv_se_reg;
		lv_de_next = lv_de_reg;
		buf_next = buf_reg;
		re_done_next = re_done_reg;
		de_done_next = de_done_reg;
		if (wr_wake) begin
			wk_clks_next = pwdata[SWL_WK_CLKS];
			wk_ie_next = pwdata[SWL_WK_IE];
			wk_sel_next = pwdata[2:0];
			if (pwdata[SWL_WK_ACK]) begin
				wk_flag_next = 1'b0;
			end
		end
		if (wr_pwr) begin
			lv_ie_next = pwdata[SWL_PW_IE];
			lv_se_next = pwdata[SWL_PW_SE];
			buf_next = pwdata[SWL_PW_BUF];
			if (!re_done_reg) begin
				lv_re_next = pwdata[SWL_PW_RE];
				re_done_next = 1'b1;
			end
			if (!de_done_reg) begin
				lv_de_next = pwdata[SWL_PW_DE];
				de_done_next = 1'b1;
			end
			if (pwdata[SWL_PW_ACK]) begin
				lv_flag_next = 1'b0;
			end
		end
		// set wins over a simultaneous acknowledge
		if (timeout) begin
			wk_flag_next = 1'b1;
		end
		if (lv_event) begin
			lv_flag_next = 1'b1;
		end
	end

	// apb read data, unmapped reads return zero
	always_comb begin
		prdata_next = prdata_reg;
		if (psel && !penable && !pwrite) begin
			prdata_next = 32'h0000_0000;
			case (paddr)
				SWL_OFF_WAKE: prdata_next[7:0] = {wk_flag_reg, 1'b0, wk_clks_reg,
					wk_ie_reg, 1'b0, wk_sel_reg};
				SWL_OFF_PWR: prdata_next[7:0] = {lv_flag_reg, 1'b0, lv_ie_reg,
					lv_re_reg, lv_se_reg, lv_de_reg, 1'b0, buf_reg};
				SWL_OFF_PEND: prdata_next[7:0] = pend;
				default: prdata_next = 32'h0000_0000;
			endcase
		end
	end

	// register all state except the input synchroniser chains
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			{wk_flag_reg, wk_clks_reg, wk_ie_reg} <= 3'h0;
			wk_sel_reg <= SWL_RST_WAKE[2:0];
			{lv_flag_reg, lv_ie_reg, lv_re_reg, lv_se_reg, lv_de_reg} <= 5'h00;
			buf_reg <= SWL_RST_PWR[SWL_PW_BUF];
			re_done_reg <= 1'b0;
			de_done_reg <= 1'b0;
			fdiv_reg <= 5'h00;
			cnt_reg <= 11'h000;
			slow_prev_reg <= 1'b0;
			fast_prev_reg <= 1'b0;
			tick_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			wk_flag_reg <= wk_flag_next;
			wk_clks_reg <= wk_clks_next;
			wk_ie_reg <= wk_ie_next;
			wk_sel_reg <= wk_sel_next;
			lv_flag_reg <= lv_flag_next;
			lv_ie_reg <= lv_ie_next;
			lv_re_reg <= lv_re_next;
			lv_se_reg <= lv_se_next;
			lv_de_reg <= lv_de_next;
			buf_reg <= buf_next;
			re_done_reg <= re_done_next;
			de_done_reg <= de_done_next;
			fdiv_reg <= fdiv_next;
			cnt_reg <= cnt_next;
			slow_prev_reg <= slow_lvl_reg;
			fast_prev_reg <= fast_lvl_reg;
			tick_reg <= tick_next;
			prdata_reg <= prdata_next;
		end
	end

	// ****************************************************
	// outputs
	// ****************************************************
	assign prdata = prdata_reg;
	assign pready = 1'b1; // zero wait states
	assign pslverr = 1'b0;
	assign periodic_wakeup_irq = wk_flag_reg && wk_ie_reg;
	assign lowvolt_irq = lv_flag_reg && lv_ie_reg && lv_de_reg;
	assign lowvolt_reset_req = lv_flag_reg && lv_re_reg && lv_de_reg;
	assign slow_osc_enable = !(stop_mode && wk_sel_reg == 3'h0 && wk_clks_reg);
	assign lowvolt_detector_on = lv_active;
	assign reference_buffer_enable = buf_reg;

	// ****************************************************
	// checks
	// ****************************************************
	sequence s_wake_ack;
		wr_wake && pwdata[SWL_WK_ACK] && !timeout;
	endsequence

	property p_wake_flag_set;
		@(posedge sys_clk) disable iff (!rstn) clk_en && timeout |=> wk_flag_reg;
	endproperty
	a_wake_flag_set: assert property (p_wake_flag_set) else $error("wake flag not set");

	property p_wake_ack;
		@(posedge sys_clk) disable iff (!rstn) (clk_en and s_wake_ack) |=> !wk_flag_reg;
	endproperty
	a_wake_ack: assert property (p_wake_ack) else $error("wake ack failed");

	property p_off_clear;
		@(posedge sys_clk) disable iff (!rstn) clk_en && wk_sel_reg == 3'h0 |=> cnt_reg == 11'h000;
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("counter not held");

	property p_lv_noset;
		@(posedge sys_clk) disable iff (!rstn)
			!lv_de_reg && !lv_flag_reg && clk_en |=> !lv_flag_reg;
	endproperty
	a_lv_noset: assert property (p_lv_noset) else $error("flag set while disabled");

	property p_lv_ack;
		@(posedge sys_clk) disable iff (!rstn)
			clk_en && wr_pwr && pwdata[SWL_PW_ACK] && !lv_event |=> !lv_flag_reg;
	endproperty
	a_lv_ack: assert property (p_lv_ack) else $error("lowvolt ack failed");

	property p_once;
		@(posedge sys_clk) disable iff (!rstn)
			clk_en && de_done_reg |=> $stable(lv_de_reg) && $stable(lv_re_reg);
	endproperty
	a_once: assert property (p_once) else $error("write-once bit changed");

	property p_lv_reset;
		@(posedge sys_clk) disable iff (!rstn)
			lowvolt_reset_req |-> lv_de_reg && lv_re_reg && lv_flag_reg;
	endproperty
	a_lv_reset: assert property (p_lv_reset) else $error("bad reset request");

	property p_pend_lv;
		@(posedge sys_clk) disable iff (!rstn) pend[SWL_PD_LV] |-> lowvolt_irq && lv_de_reg;
	endproperty
	a_pend_lv: assert property (p_pend_lv) else $error("summary lv mismatch");

	property p_osc_off;
		@(posedge sys_clk) disable iff (!rstn)
			!slow_osc_enable |-> stop_mode && wk_clks_reg && wk_sel_reg == 3'h0;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("osc off wrongly");

	// a write without acknowledge leaves the wakeup flag alone
	property p_wake_hold;
		@(posedge sys_clk) disable iff (!rstn)
			clk_en && wr_wake && !pwdata[SWL_WK_ACK] && !timeout |=> wk_flag_reg == $past(wk_flag_reg);
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake flag changed by write");

	// the counter restarts after each timeout
	property p_cnt_restart;
		@(posedge sys_clk) disable iff (!rstn) clk_en && timeout |=> cnt_reg == 11'h000;
	endproperty
	a_cnt_restart: assert property (p_cnt_restart) else $error("counter not restarted");

	// while the timer is on, the counter moves only on a tick
	property p_cnt_hold;
		@(posedge sys_clk) disable iff (!rstn)
			clk_en && wk_sel_reg != 3'h0 && !tick_reg |=> $stable(cnt_reg);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without tick");

	// detect enable off silences every lowvolt output
	property p_de_gate;
		@(posedge sys_clk) disable iff (!rstn)
			!lv_de_reg |-> !lowvolt_irq && !lowvolt_reset_req && !lowvolt_detector_on;
	endproperty
	a_de_gate: assert property (p_de_gate) else $error("lowvolt active while disabled");

	// the buffer enable follows each power register write
	property p_buf;
		@(posedge sys_clk) disable iff (!rstn)
			clk_en && wr_pwr |=> reference_buffer_enable == $past(pwdata[SWL_PW_BUF]);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer enable not written");

endmodule : swl_ctrl

// ==== verification/tb_swl_ctrl.sv ====
// tb_swl_ctrl: self-checking bench for the wakeup, low-voltage and pending block.
// assumes swl_pkg is compiled first; the bench drives apb and every source pin.
`timescale 1ns/1ps
module tb_swl_ctrl;
	import swl_pkg::*;
	// ****************************************************
	// clock, reset and pins
	// ****************************************************
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic slow_osc_clk = 1'b0;
	logic fast_osc_clk = 1'b0;
	logic lowvolt_detect = 1'b0;
	logic [5:0] src = 6'h00; // keypad, comparator, timer flag/enable pairs
	logic stop_mode = 1'b0;
	logic wk_irq, lv_irq, lv_rst, osc_en, det_on, buf_en;
	logic [31:0] rd;
	int bad_count = 0;
	int samples_checked = 0;
	int cnt;

	// free-running 100 mhz clock
	always #5 sys_clk = ~sys_clk;

	swl_ctrl u_dut (
		.sys_clk(sys_clk), .clk_en(clk_en), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slow_osc_clk(slow_osc_clk), .fast_osc_clk(fast_osc_clk),
		.lowvolt_detect(lowvolt_detect),
		.keypad_flag(src[5]), .keypad_irq_enable(src[4]),
		.comparator_flag(src[3]), .comparator_irq_enable(src[2]),
		.timer_overflow_flag(src[1]), .timer_overflow_irq_enable(src[0]),
		.stop_mode(stop_mode), .periodic_wakeup_irq(wk_irq), .lowvolt_irq(lv_irq),
		.lowvolt_reset_req(lv_rst), .slow_osc_enable(osc_en),
		.lowvolt_detector_on(det_on), .reference_buffer_enable(buf_en)
	);

	// ****************************************************
	// report and compare
	// ****************************************************
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	task check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word

	task check_bit(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask : check_bit

	// ****************************************************
	// bus cycles and pin helpers
	// ****************************************************
	task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			$display("mismatch pready expected 1 seen timeout");
			end_sim();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb_xfer

	task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb_xfer(1'b0, a, 32'h0);
		check_word(name, exp, rd);
	endtask : rd_chk

	// let n edges pass, then sample after updates have landed
	task settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle

	task reset_dut;
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
	endtask : reset_dut

	// one slow tick lasts 8 cycles, fast ticks 4 cycles each
	task slow_tick;
		@(posedge sys_clk);
		slow_osc_clk <= 1'b1;
		repeat (4) @(posedge sys_clk);
		slow_osc_clk <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask : slow_tick

	task fast_ticks(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			fast_osc_clk <= 1'b1;
			repeat (2) @(posedge sys_clk);
			fast_osc_clk <= 1'b0;
			@(posedge sys_clk);
		end
	endtask : fast_ticks

	task lv_pulse(input logic v);
		@(posedge sys_clk);
		lowvolt_detect <= v;
		settle(7);
	endtask : lv_pulse

	// ****************************************************
	// scenarios
	// ****************************************************
	task sc_reset_map;
		rd_chk("wake", SWL_OFF_WAKE, 32'h0);
		rd_chk("pwr", SWL_OFF_PWR, 32'h0);
		rd_chk("pend", SWL_OFF_PEND, 32'h0);
		apb_xfer(1'b1, 8'h0c, 32'hff);
		rd_chk("unmapped", 8'h0c, 32'h0);
		check_bit("pslverr", 1'b0, pslverr);
		rd_chk("wake", SWL_OFF_WAKE, 32'h0);
		check_bit("osc_en", 1'b1, osc_en);
	endtask : sc_reset_map

	task sc_pending;
		for (int i = 0; i < 64; i++) begin
			@(posedge sys_clk);
			src <= i[5:0];
			apb_xfer(1'b0, SWL_OFF_PEND, 32'h0);
			check_word("pend", {27'h0, i[5] & i[4], i[3] & i[2], i[1] & i[0], 2'b00}, rd);
		end
		@(posedge sys_clk);
		src <= 6'h00;
	endtask : sc_pending

	task sc_periods;
		for (int s = 1; s < 8; s++) begin
			apb_xfer(1'b1, SWL_OFF_WAKE, 32'h50 | s);
			settle(1);
			check_bit("wk_irq", 1'b0, wk_irq);
			cnt = 0;
			while (wk_irq !== 1'b1 && cnt < 1100) begin
				slow_tick();
				settle(1);
				cnt++;
			end
			check_word("period", (s == 1) ? 32'd8 : (32'd8 << s), cnt);
		end
		rd_chk("wake", SWL_OFF_WAKE, 32'h97);
		rd_chk("pend", SWL_OFF_PEND, 32'h02);
		apb_xfer(1'b1, SWL_OFF_WAKE, 32'h07);
		settle(1);
		check_bit("wk_irq", 1'b0, wk_irq);
		rd_chk("pend", SWL_OFF_PEND, 32'h00);
		rd_chk("wake", SWL_OFF_WAKE, 32'h87);
		apb_xfer(1'b1, SWL_OFF_WAKE, 32'h17);
		rd_chk("wake", SWL_OFF_WAKE, 32'h97);
		apb_xfer(1'b1, SWL_OFF_WAKE, 32'h57);
		rd_chk("wake", SWL_OFF_WAKE, 32'h17);
		// a write while the clock enable is low must not land
		@(posedge sys_clk);
		clk_en <= 1'b0;
		apb_xfer(1'b1, SWL_OFF_WAKE, 32'h00);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rd_chk("wake", SWL_OFF_WAKE, 32'h17);
	endtask : sc_periods

	task sc_off_and_fast;
		apb_xfer(1'b1, SWL_OFF_WAKE, 32'h10);
		repeat (20) slow_tick();
		rd_chk("wake", SWL_OFF_WAKE, 32'h10);
		@(posedge sys_clk);
		stop_mode <= 1'b1;
		settle(2);
		check_bit("osc_en", 1'b1, osc_en);
		apb_xfer(1'b1, SWL_OFF_WAKE, 32'h20);
		settle(2);
		check_bit("osc_en", 1'b0, osc_en);
		apb_xfer(1'b1, SWL_OFF_WAKE, 32'h21);
		settle(2);
		check_bit("osc_en", 1'b1, osc_en);
		@(posedge sys_clk);
		stop_mode <= 1'b0;
		apb_xfer(1'b1, SWL_OFF_WAKE, 32'h31);
		fast_ticks(8 * SWL_FAST_DIV - SWL_FAST_DIV);
		repeat (8) slow_tick();
		settle(4);
		check_bit("wk_irq", 1'b0, wk_irq);
		fast_ticks(SWL_FAST_DIV);
		settle(8);
		check_bit("wk_irq", 1'b1, wk_irq);
	endtask : sc_off_and_fast

	task sc_lowvolt;
		reset_dut();
		lv_pulse(1'b1);
		rd_chk("pwr", SWL_OFF_PWR, 32'h0);
		lv_pulse(1'b0);
		apb_xfer(1'b1, SWL_OFF_PWR, 32'h2d);
		rd_chk("pwr", SWL_OFF_PWR, 32'h2d);
		check_bit("det_on", 1'b1, det_on);
		check_bit("buf_en", 1'b1, buf_en);
		lv_pulse(1'b1);
		check_bit("lv_irq", 1'b1, lv_irq);
		check_bit("lv_rst", 1'b0, lv_rst);
		rd_chk("pwr", SWL_OFF_PWR, 32'had);
		rd_chk("pend", SWL_OFF_PEND, 32'h01);
		lv_pulse(1'b0);
		apb_xfer(1'b1, SWL_OFF_PWR, 32'h71);
		rd_chk("pwr", SWL_OFF_PWR, 32'h25);
		check_bit("lv_irq", 1'b0, lv_irq);
		@(posedge sys_clk);
		stop_mode <= 1'b1;
		settle(2);
		check_bit("det_on", 1'b0, det_on);
		apb_xfer(1'b1, SWL_OFF_PWR, 32'h29);
		settle(1);
		check_bit("det_on", 1'b1, det_on);
		@(posedge sys_clk);
		stop_mode <= 1'b0;
		lv_pulse(1'b1);
		check_bit("lv_rst", 1'b0, lv_rst);
		lv_pulse(1'b0);
		reset_dut();
		apb_xfer(1'b1, SWL_OFF_PWR, 32'h14);
		lv_pulse(1'b1);
		check_bit("lv_rst", 1'b1, lv_rst);
		check_bit("lv_irq", 1'b0, lv_irq);
		rd_chk("pend", SWL_OFF_PEND, 32'h00);
		lv_pulse(1'b0);
		apb_xfer(1'b1, SWL_OFF_PWR, 32'h40);
		settle(1);
		check_bit("lv_rst", 1'b0, lv_rst);
		check_bit("buf_en", 1'b0, buf_en);
	endtask : sc_lowvolt

	// main sequence
	initial begin
		reset_dut();
		sc_reset_map();
		sc_pending();
		sc_periods();
		sc_off_and_fast();
		sc_lowvolt();
		end_sim();
	end

endmodule : tb_swl_ctrl
